// ===== src/pin_sync.sv
/*
   Two-flop synchroniser for one level from outside the clock domain.
   Assumes the input is slow compared with ref_clk.
*/
`timescale 1ns/1ps
module pin_sync
   import upper_bank_pkg::*;
#(
   parameter logic RESET_LEVEL = 1'b0
) (
   input  wire logic ref_clk,
   input  wire logic nrst,
   input  wire logic pin_in,
   output logic      pin_sync_out
);

   typedef struct packed {
      logic first;
      logic second;
   } sync_state_t;

   sync_state_t state;
   sync_state_t next_state;

   always_comb begin
      next_state.first  = pin_in;
      next_state.second = state.first;
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         state <= '{first: RESET_LEVEL, second: RESET_LEVEL};
      end else begin
         state <= next_state;
      end
   end

   assign pin_sync_out = state.second;

endmodule // pin_sync

// ===== src/upper_bank_pkg.sv
/*
   Constants, field layouts and carrier types for the upper special
   function register bank (locations 80h to 9Fh plus the mirrored core
   registers). Assumes a single clock domain and an 8-bit core bus.
*/
package upper_bank_pkg;

   // ----------------------------------------------------------------
   // register addresses
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_INDIRECT_PORT   = 8'h80;
   localparam logic [7:0] ADDR_OPTION_CONFIG   = 8'h81;
   localparam logic [7:0] ADDR_PC_LOW_BYTE     = 8'h82;
   localparam logic [7:0] ADDR_CORE_FLAGS      = 8'h83;
   localparam logic [7:0] ADDR_INDIRECT_PTR    = 8'h84;
   localparam logic [7:0] ADDR_PORT_A_DIR      = 8'h85;
   localparam logic [7:0] ADDR_PORT_B_DIR      = 8'h86;
   localparam logic [7:0] ADDR_PORT_C_DIR      = 8'h87;
   localparam logic [7:0] ADDR_PC_HIGH_HOLD    = 8'h8A;
   localparam logic [7:0] ADDR_IRQ_CTRL_MAIN   = 8'h8B;
   localparam logic [7:0] ADDR_PERIPH_IRQ_EN   = 8'h8C;
   localparam logic [7:0] ADDR_RESET_CAUSE     = 8'h8E;
   localparam logic [7:0] ADDR_TIMER2_PERIOD   = 8'h92;
   localparam logic [7:0] ADDR_SERIAL_ADDRESS  = 8'h93;
   localparam logic [7:0] ADDR_SERIAL_STATE    = 8'h94;
   localparam logic [7:0] ADDR_CONVERTER_PINS  = 8'h9F;
   localparam logic [7:0] BANK_SELECT_BIT      = 8'h80;

   // ----------------------------------------------------------------
   // implemented bit masks
   // ----------------------------------------------------------------
   localparam logic [7:0] MASK_PORT_A_DIR      = 8'h3F;
   localparam logic [7:0] MASK_PERIPH_IRQ_EN   = 8'h4F;
   localparam logic [7:0] MASK_RESET_CAUSE     = 8'h03;
   localparam logic [7:0] MASK_SERIAL_STATE    = 8'h3F;
   localparam logic [7:0] MASK_CONVERTER_PINS  = 8'h07;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int FLAG_WDT_EXPIRY   = 4;
   localparam int FLAG_SLEEP_ENTRY  = 3;
   localparam int CAUSE_POWER_UP    = 1;
   localparam int CAUSE_SUPPLY_DIP  = 0;
   localparam int PC_WIDTH          = 13;
   localparam int PC_HIGH_WIDTH     = 5;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_ALL_ONES         = 8'hFF;
   localparam logic [7:0] RST_ZERO             = 8'h00;
   localparam logic [7:0] RST_PORT_A_DIR       = 8'h3F;
   localparam logic [7:0] RST_FLAGS_POWER_UP   = 8'h18;
   localparam logic [7:0] KEEP_FLAGS_OTHER     = 8'h1F;
   localparam logic [7:0] KEEP_IRQ_CTRL_OTHER  = 8'h01;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } bus_req_t;

   typedef struct packed {
      logic       wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } mem_write_t;

   typedef struct packed {
      logic [7:0] option_config;
      logic [7:0] core_flags;
      logic [7:0] port_a_direction;
      logic [7:0] port_b_direction;
      logic [7:0] port_c_direction;
      logic [7:0] interrupt_control_main;
      logic [7:0] peripheral_irq_enable;
      logic [7:0] reset_cause;
      logic [7:0] timer2_period;
      logic [7:0] serial_slave_address;
      logic [7:0] converter_pin_config;
   } config_out_t;

   typedef struct packed {
      logic       flags_we;
      logic [2:0] flags;
      logic       clear_watchdog;
      logic       sleep_enter;
      logic       pc_advance;
      logic       pc_transfer;
   } core_events_t;

endpackage

// ===== src/upper_bank_sfr_map.sv
/*
   Upper special function register bank: decode, storage and reset
   behaviour, mirrored core registers, program counter and indirect
   access. Assumes the core drives the register port on ref_clk and
   that data memory answers a read combinationally in the same cycle.
*/
`timescale 1ns/1ps
module upper_bank_sfr_map
   import upper_bank_pkg::*;
(
   input  wire logic           ref_clk,
   input  wire logic           nrst,
   input  wire bus_req_t       bus_req,
   output logic [7:0]          bus_rdata,
   input  wire core_events_t   core_events,
   input  wire logic [5:0]     serial_state_in,
   input  wire logic           watchdog_reset,
   input  wire logic           external_reset_pin_n,
   input  wire logic           supply_dip_reset,
   output logic [7:0]          mem_rd_addr,
   input  wire logic [7:0]     mem_rdata,
   output mem_write_t          mem_write,
   output logic [PC_WIDTH-1:0] pc,
   output config_out_t         config_out
);

   typedef struct packed {
      logic [7:0]          rdata;
      logic [7:0]          indirect_pointer;
      logic [PC_WIDTH-1:0] pc;
      logic [7:0]          pc_high_holding;
      logic [7:0]          serial_port_state;
      mem_write_t          mem_write;
      config_out_t         cfg;
      logic                ext_reset_seen;
   } bank_state_t;

   bank_state_t state;
   bank_state_t next_state;
   logic        ext_reset_n_sync;
   logic        supply_dip_sync;

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   pin_sync #(
      .RESET_LEVEL (1'b1)
   ) u_ext_reset_sync (
      .ref_clk      (ref_clk),
      .nrst         (nrst),
      .pin_in       (external_reset_pin_n),
      .pin_sync_out (ext_reset_n_sync)
   );

   pin_sync #(
      .RESET_LEVEL (1'b0)
   ) u_supply_dip_sync (
      .ref_clk      (ref_clk),
      .nrst         (nrst),
      .pin_in       (supply_dip_reset),
      .pin_sync_out (supply_dip_sync)
   );

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // mirrored core registers ignore the bank bit
   function automatic logic hit_mirror(input logic [7:0] a, input logic [7:0] reg_addr);
      hit_mirror = ((a | BANK_SELECT_BIT) == reg_addr);
   endfunction

   function automatic logic [7:0] read_mux(input bank_state_t s, input logic [7:0] a,
                                           input logic [7:0] mem_data);
      read_mux = RST_ZERO;
      if (hit_mirror(a, ADDR_INDIRECT_PORT)) begin
         read_mux = mem_data;
      end else if (hit_mirror(a, ADDR_PC_LOW_BYTE)) begin
         read_mux = s.pc[7:0];
      end else if (hit_mirror(a, ADDR_CORE_FLAGS)) begin
         read_mux = s.cfg.core_flags;
      end else if (hit_mirror(a, ADDR_INDIRECT_PTR)) begin
         read_mux = s.indirect_pointer;
      end else if (hit_mirror(a, ADDR_PC_HIGH_HOLD)) begin
         read_mux = s.pc_high_holding;
      end else if (hit_mirror(a, ADDR_IRQ_CTRL_MAIN)) begin
         read_mux = s.cfg.interrupt_control_main;
      end else begin
         unique case (a)
            ADDR_OPTION_CONFIG:  read_mux = s.cfg.option_config;
            ADDR_PORT_A_DIR:     read_mux = s.cfg.port_a_direction;
            ADDR_PORT_B_DIR:     read_mux = s.cfg.port_b_direction;
            ADDR_PORT_C_DIR:     read_mux = s.cfg.port_c_direction;
            ADDR_PERIPH_IRQ_EN:  read_mux = s.cfg.peripheral_irq_enable;
            ADDR_RESET_CAUSE:    read_mux = s.cfg.reset_cause;
            ADDR_TIMER2_PERIOD:  read_mux = s.cfg.timer2_period;
            ADDR_SERIAL_ADDRESS: read_mux = s.cfg.serial_slave_address;
            ADDR_SERIAL_STATE:   read_mux = s.serial_port_state;
            ADDR_CONVERTER_PINS: read_mux = s.cfg.converter_pin_config;
            default:             read_mux = RST_ZERO;
         endcase
      end
   endfunction

   // values common to power-up and other resets
   function automatic bank_state_t common_reset(input bank_state_t s);
      bank_state_t r;
      r                              = s;
      r.rdata                        = RST_ZERO;
      r.pc                           = '0;
      r.pc_high_holding              = RST_ZERO;
      r.serial_port_state            = RST_ZERO;
      r.mem_write                    = '0;
      r.cfg.option_config            = RST_ALL_ONES;
      r.cfg.port_a_direction         = RST_PORT_A_DIR;
      r.cfg.port_b_direction         = RST_ALL_ONES;
      r.cfg.port_c_direction         = RST_ALL_ONES;
      r.cfg.timer2_period            = RST_ALL_ONES;
      r.cfg.serial_slave_address     = RST_ZERO;
      r.cfg.peripheral_irq_enable    = RST_ZERO;
      r.cfg.converter_pin_config     = RST_ZERO;
      r.cfg.interrupt_control_main   = s.cfg.interrupt_control_main & KEEP_IRQ_CTRL_OTHER;
      r.cfg.core_flags               = s.cfg.core_flags & KEEP_FLAGS_OTHER;
      common_reset                   = r;
   endfunction

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      logic [7:0] a;
      logic [7:0] d;
      logic       ext_edge;
      a          = bus_req.addr;
      d          = bus_req.wdata;
      ext_edge   = !ext_reset_n_sync && !state.ext_reset_seen;
      next_state = state;

      next_state.ext_reset_seen    = !ext_reset_n_sync;
      next_state.mem_write.wr      = 1'b0;
      next_state.serial_port_state = {2'b00, serial_state_in} & MASK_SERIAL_STATE;
      next_state.rdata             = RST_ZERO;
      if (bus_req.rd) begin
         next_state.rdata = read_mux(state, a, mem_rdata);
      end

      // program counter sequencing
      if (core_events.pc_advance) begin
         next_state.pc = state.pc + PC_WIDTH'(1);
      end
      if (core_events.pc_transfer) begin
         next_state.pc[PC_WIDTH-1:8] = state.pc_high_holding[PC_HIGH_WIDTH-1:0];
      end

      // register writes
      if (bus_req.wr) begin
         if (hit_mirror(a, ADDR_INDIRECT_PORT)) begin
            next_state.mem_write.wr    = 1'b1;
            next_state.mem_write.addr  = state.indirect_pointer;
            next_state.mem_write.wdata = d;
         end else if (hit_mirror(a, ADDR_PC_LOW_BYTE)) begin
            next_state.pc = {state.pc_high_holding[PC_HIGH_WIDTH-1:0], d};
         end else if (hit_mirror(a, ADDR_CORE_FLAGS)) begin
            // expiry and sleep flags stay as they are
            next_state.cfg.core_flags[7:5] = d[7:5];
            next_state.cfg.core_flags[2:0] = d[2:0];
         end else if (hit_mirror(a, ADDR_INDIRECT_PTR)) begin
            next_state.indirect_pointer = d;
         end else if (hit_mirror(a, ADDR_PC_HIGH_HOLD)) begin
            next_state.pc_high_holding = {3'b000, d[PC_HIGH_WIDTH-1:0]};
         end else if (hit_mirror(a, ADDR_IRQ_CTRL_MAIN)) begin
            next_state.cfg.interrupt_control_main = d;
         end else begin
            unique case (a)
               ADDR_OPTION_CONFIG:  next_state.cfg.option_config = d;
               ADDR_PORT_A_DIR:     next_state.cfg.port_a_direction = d & MASK_PORT_A_DIR;
               ADDR_PORT_B_DIR:     next_state.cfg.port_b_direction = d;
               ADDR_PORT_C_DIR:     next_state.cfg.port_c_direction = d;
               ADDR_PERIPH_IRQ_EN:
                  next_state.cfg.peripheral_irq_enable = d & MASK_PERIPH_IRQ_EN;
               ADDR_RESET_CAUSE:    next_state.cfg.reset_cause = d & MASK_RESET_CAUSE;
               ADDR_TIMER2_PERIOD:  next_state.cfg.timer2_period = d;
               ADDR_SERIAL_ADDRESS: next_state.cfg.serial_slave_address = d;
               ADDR_CONVERTER_PINS:
                  next_state.cfg.converter_pin_config = d & MASK_CONVERTER_PINS;
               default:             next_state.cfg = state.cfg;
            endcase
         end
      end

      // arithmetic result overrides a same-cycle status write
      if (core_events.flags_we) begin
         next_state.cfg.core_flags[2:0] = core_events.flags;
      end

      // expiry and sleep flags follow the core and the resets below, never a bus write
      if (core_events.clear_watchdog) begin
         next_state.cfg.core_flags[FLAG_WDT_EXPIRY]  = 1'b1;
         next_state.cfg.core_flags[FLAG_SLEEP_ENTRY] = 1'b1;
      end else if (core_events.sleep_enter) begin
         next_state.cfg.core_flags[FLAG_WDT_EXPIRY]  = 1'b1;
         next_state.cfg.core_flags[FLAG_SLEEP_ENTRY] = 1'b0;
      end

      // synchronous resets, supply dip first
      if (supply_dip_sync) begin
         next_state = common_reset(state);
         next_state.ext_reset_seen                          = !ext_reset_n_sync;
         next_state.cfg.core_flags                          = RST_FLAGS_POWER_UP;
         next_state.cfg.interrupt_control_main              = RST_ZERO;
         next_state.cfg.reset_cause[CAUSE_SUPPLY_DIP]       = 1'b0;
      end else if (watchdog_reset) begin
         next_state = common_reset(state);
         next_state.ext_reset_seen                          = !ext_reset_n_sync;
         next_state.cfg.core_flags[FLAG_WDT_EXPIRY]         = 1'b0;
         next_state.cfg.core_flags[FLAG_SLEEP_ENTRY]        = 1'b1;
      end else if (ext_edge || !ext_reset_n_sync) begin
         next_state = common_reset(state);
         next_state.ext_reset_seen                          = !ext_reset_n_sync;
      end
   end

   // ----------------------------------------------------------------
   // state register, power-up values
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         state                            <= '0;
         state.cfg.option_config          <= RST_ALL_ONES;
         state.cfg.port_a_direction       <= RST_PORT_A_DIR;
         state.cfg.port_b_direction       <= RST_ALL_ONES;
         state.cfg.port_c_direction       <= RST_ALL_ONES;
         state.cfg.timer2_period          <= RST_ALL_ONES;
         state.cfg.core_flags             <= RST_FLAGS_POWER_UP;
         state.cfg.reset_cause            <= RST_ZERO;
      end else begin
         state <= next_state;
      end
   end

   // ----------------------------------------------------------------
   // outputs, all from flops
   // ----------------------------------------------------------------
   assign bus_rdata   = state.rdata;
   assign mem_rd_addr = state.indirect_pointer;
   assign mem_write   = state.mem_write;
   assign pc          = state.pc;
   assign config_out  = state.cfg;

endmodule // upper_bank_sfr_map

// ===== tb/upper_bank_chk.sv
/*
   Checker for the upper register bank; sees only the top ports.
   Assumes one clock domain and the registered timing of the bank.
*/
`timescale 1ns/1ps
module upper_bank_chk
   import upper_bank_pkg::*;
(
   input wire logic                ref_clk,
   input wire logic                nrst,
   input wire bus_req_t            bus_req,
   input wire logic [7:0]          bus_rdata,
   input wire core_events_t        core_events,
   input wire logic [5:0]          serial_state_in,
   input wire logic                watchdog_reset,
   input wire logic                external_reset_pin_n,
   input wire logic                supply_dip_reset,
   input wire logic [7:0]          mem_rd_addr,
   input wire logic [7:0]          mem_rdata,
   input wire mem_write_t          mem_write,
   input wire logic [PC_WIDTH-1:0] pc,
   input wire config_out_t         config_out
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);

   // ------------------------------------------------------------
   // sequences
   // ------------------------------------------------------------
   sequence s_hold_then_low;
      (bus_req.wr && bus_req.addr[6:0] == 7'h0A) ##2 (bus_req.wr && bus_req.addr[6:0] == 7'h02);
   endsequence
   sequence s_flag_write;
      bus_req.wr && bus_req.addr[6:0] == 7'h03 && core_events == '0 && !watchdog_reset;
   endsequence

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   chk_unmapped_zero: assert property (bus_req.rd && bus_req.addr inside
      {8'h88, 8'h89, 8'h8D, [8'h8F:8'h91], [8'h95:8'h9E]} |=> bus_rdata == 8'h00)
      else $error("unmapped read not zero");
   chk_serial_top: assert property (bus_req.rd && bus_req.addr == 8'h94
      |=> bus_rdata[7:6] == 2'b00) else $error("serial state top bits set");
   chk_pc_jump: assert property (s_hold_then_low
      |=> pc == {$past(bus_req.wdata[4:0], 3), $past(bus_req.wdata)})
      else $error("pc jump target wrong");
   chk_status_ro: assert property (s_flag_write
      |=> $stable(config_out.core_flags[4:3])) else $error("expiry or sleep flag written");
   chk_arith_flags: assert property (core_events.flags_we && !watchdog_reset
      |=> config_out.core_flags[2:0] == $past(core_events.flags))
      else $error("arithmetic flags not applied");
   chk_wdt_flags: assert property (watchdog_reset
      |=> config_out.core_flags[4:3] == 2'b01) else $error("watchdog flags wrong");
   chk_wdt_values: assert property (watchdog_reset |=> config_out.option_config == 8'hFF
      && config_out.port_a_direction == 8'h3F && config_out.port_b_direction == 8'hFF
      && config_out.timer2_period == 8'hFF && config_out.serial_slave_address == 8'h00
      && pc == 13'h0000) else $error("other reset values wrong");
   chk_pointer_mirror: assert property (bus_req.wr && bus_req.addr[6:0] == 7'h04
      |=> mem_rd_addr == $past(bus_req.wdata)) else $error("pointer write lost");
   chk_indirect_wr: assert property (bus_req.wr && bus_req.addr[6:0] == 7'h00
      |=> mem_write.wr && mem_write.addr == mem_rd_addr
      && mem_write.wdata == $past(bus_req.wdata)) else $error("indirect write wrong");
   chk_no_stray_wr: assert property (!(bus_req.wr && bus_req.addr[6:0] == 7'h00)
      |=> !mem_write.wr) else $error("stray memory write");
endmodule // upper_bank_chk

bind upper_bank_sfr_map upper_bank_chk u_chk (.ref_clk(ref_clk), .nrst(nrst),
   .bus_req(bus_req), .bus_rdata(bus_rdata), .core_events(core_events),
   .serial_state_in(serial_state_in), .watchdog_reset(watchdog_reset),
   .external_reset_pin_n(external_reset_pin_n), .supply_dip_reset(supply_dip_reset),
   .mem_rd_addr(mem_rd_addr), .mem_rdata(mem_rdata), .mem_write(mem_write), .pc(pc),
   .config_out(config_out));

// ===== tb/upper_bank_sfr_map_bench.sv
/*
   Self-checking bench for the upper register bank.
   Assumes data memory answers combinationally; modelled as address xor A5.
*/
`timescale 1ns/1ps
module upper_bank_sfr_map_bench;
   import upper_bank_pkg::*;
   logic                ref_clk = 1'b0;
   logic                nrst = 1'b0;
   bus_req_t            bus_req = '0;
   core_events_t        core_events = '0;
   logic [5:0]          serial_state_in = '0;
   logic                watchdog_reset = 1'b0;
   logic                external_reset_pin_n = 1'b1;
   logic                supply_dip_reset = 1'b0;
   logic [7:0]          bus_rdata, mem_rd_addr, mem_rdata;
   mem_write_t          mem_write;
   logic [PC_WIDTH-1:0] pc;
   config_out_t         config_out;
   int                  n_mismatch = 0;
   int                  checks = 0;

   assign mem_rdata = mem_rd_addr ^ 8'hA5;
   always #5 ref_clk = ~ref_clk;

   upper_bank_sfr_map dut (.ref_clk(ref_clk), .nrst(nrst), .bus_req(bus_req),
      .bus_rdata(bus_rdata), .core_events(core_events), .serial_state_in(serial_state_in),
      .watchdog_reset(watchdog_reset), .external_reset_pin_n(external_reset_pin_n),
      .supply_dip_reset(supply_dip_reset), .mem_rd_addr(mem_rd_addr), .mem_rdata(mem_rdata),
      .mem_write(mem_write), .pc(pc), .config_out(config_out));

   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      bus_req.wr <= 1'b1;
      bus_req.addr <= a;
      bus_req.wdata <= d;
      @(posedge ref_clk);
      bus_req.wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge ref_clk);
      bus_req.rd <= 1'b1;
      bus_req.addr <= a;
      @(posedge ref_clk);
      bus_req.rd <= 1'b0;
      #1;
      check($sformatf("read %h", a), {16'h0000, bus_rdata}, {16'h0000, exp});
   endtask
   task automatic ev(input core_events_t e);
      @(posedge ref_clk);
      core_events <= e;
      @(posedge ref_clk);
      core_events <= '0;
      #1;
   endtask
   task automatic pulse_pin(input logic dip);
      @(posedge ref_clk);
      if (dip) begin
         supply_dip_reset <= 1'b1;
      end else begin
         external_reset_pin_n <= 1'b0;
      end
      repeat (4) @(posedge ref_clk);
      supply_dip_reset <= 1'b0;
      external_reset_pin_n <= 1'b1;
      repeat (6) @(posedge ref_clk);
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_reset();
      logic [7:0] a[16] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'h87,
                            8'h8A, 8'h8B, 8'h8C, 8'h8E, 8'h92, 8'h93, 8'h94, 8'h9F};
      logic [7:0] e[16] = '{8'hA5, 8'hFF, 8'h00, 8'h18, 8'h00, 8'h3F, 8'hFF, 8'hFF,
                            8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00};
      for (int i = 0; i < 16; i++) rd(a[i], e[i]);
      check("pc", 24'(pc), 24'h0);
   endtask
   task automatic t_masks();
      logic [7:0] a[16] = '{8'h81, 8'h85, 8'h8A, 8'h8C, 8'h8E, 8'h93, 8'h94, 8'h9F,
                            8'h88, 8'h89, 8'h8D, 8'h8F, 8'h90, 8'h91, 8'h95, 8'h9E};
      logic [7:0] e[16] = '{8'hFF, 8'h3F, 8'h1F, 8'h4F, 8'h03, 8'hFF, 8'h00, 8'h07,
                            8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
      for (int i = 0; i < 16; i++) begin
         wr(a[i], 8'hFF);
         rd(a[i], e[i]);
      end
      @(posedge ref_clk);
      serial_state_in <= 6'h3F;
      rd(8'h94, 8'h3F);
   endtask
   task automatic t_mirror();
      wr(8'h04, 8'h20);
      #1 check("pointer", 24'(mem_rd_addr), 24'h20);
      rd(8'h84, 8'h20);
      wr(8'h00, 8'h55);
      #1 check("mem write", 24'(mem_write), 24'h12055);
      @(posedge ref_clk);
      #1 check("mem write end", 24'(mem_write.wr), 24'h0);
      rd(8'h80, 8'h85);
      rd(8'h00, 8'h85);
      wr(8'h8B, 8'h81);
      rd(8'h0B, 8'h81);
   endtask
   task automatic t_pc();
      wr(8'h0A, 8'h12);
      wr(8'h82, 8'h34);
      #1 check("pc jump", 24'(pc), 24'h1234);
      wr(8'h8A, 8'h07);
      ev('{pc_transfer: 1'b1, default: '0});
      check("pc transfer", 24'(pc), 24'h0734);
      ev('{pc_advance: 1'b1, default: '0});
      check("pc advance", 24'(pc), 24'h0735);
   endtask
   task automatic t_status();
      wr(8'h83, 8'h00);
      rd(8'h83, 8'h18);
      wr(8'h83, 8'h07);
      rd(8'h83, 8'h1F);
      @(posedge ref_clk);
      bus_req.wr <= 1'b1;
      bus_req.addr <= 8'h83;
      bus_req.wdata <= 8'h00;
      core_events <= '{flags_we: 1'b1, flags: 3'b101, default: '0};
      @(posedge ref_clk);
      bus_req.wr <= 1'b0;
      core_events <= '0;
      rd(8'h83, 8'h1D);
      ev('{sleep_enter: 1'b1, default: '0});
      rd(8'h83, 8'h15);
      ev('{clear_watchdog: 1'b1, default: '0});
      rd(8'h83, 8'h1D);
   endtask
   task automatic t_resets();
      wr(8'h86, 8'h00);
      wr(8'h81, 8'h5A);
      wr(8'h84, 8'h33);
      @(posedge ref_clk);
      watchdog_reset <= 1'b1;
      @(posedge ref_clk);
      watchdog_reset <= 1'b0;
      #1 check("pc other reset", 24'(pc), 24'h0);
      rd(8'h86, 8'hFF);
      rd(8'h81, 8'hFF);
      rd(8'h84, 8'h33);
      rd(8'h8E, 8'h03);
      rd(8'h83, 8'h0D);
      rd(8'h8B, 8'h01);
      rd(8'h93, 8'h00);
      wr(8'h86, 8'h00);
      pulse_pin(1'b0);
      rd(8'h86, 8'hFF);
      rd(8'h83, 8'h0D);
      wr(8'h92, 8'h00);
      pulse_pin(1'b1);
      rd(8'h83, 8'h18);
      rd(8'h8E, 8'h02);
      rd(8'h8B, 8'h00);
      check("timer2 cfg", 24'(config_out.timer2_period), 24'hFF);
   endtask

   // ------------------------------------------------------------
   // run control
   // ------------------------------------------------------------
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (2) @(posedge ref_clk);
      nrst <= 1'b1;
      t_reset();
      t_masks();
      t_mirror();
      t_pc();
      t_status();
      t_resets();
      complete_run();
   end
   initial begin
      repeat (20000) @(posedge ref_clk);
      n_mismatch++;
      complete_run();
   end
endmodule // upper_bank_sfr_map_bench
